// file: rtl/bfc_unit.sv
// Bit, flag and control operation unit of an 8-bit core
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module bfc_unit (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire bfc_pkg::bfc_req_t req,
  input  wire logic [7:0]        flagsIn,
  output logic                   resultValid,
  output logic                   writeBack,
  output logic [7:0]             result,
  output logic [7:0]             flagsOut,
  output logic                   sleepReq,
  output logic                   watchdogRestart,
  output logic                   debugBreak
);
  import bfc_pkg::*;

  // Logic retires every op in one cycle and is built for one byte only
  if (DATA_W != 8 || EXEC_CYCLES != 1) begin : g_bad_config
    $error("bfc_unit serves one-cycle byte operations only");
  end

  bfc_state_t state_ff;
  bfc_state_t nxt_state;

  // Shift flags: S = N ^ V, V = N ^ C after the shift
  function automatic logic [7:0] shiftFlags(input logic [7:0] f, input logic [7:0] r,
                                            input logic c);
    logic [7:0] o;
    o = f;
    o[FLAG_C] = c;
    o[FLAG_Z] = (r == 8'h00);
    o[FLAG_N] = r[7];
    o[FLAG_V] = r[7] ^ c;
    o[FLAG_S] = o[FLAG_N] ^ o[FLAG_V];
    return o;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [7:0] r;
    logic [7:0] f;
    r = req.operand;
    f = flagsIn;
    nxt_state = '0;
    nxt_state.flags = state_ff.flags;
    nxt_state.result = state_ff.result;
    if (req.valid) begin
      nxt_state.resultValid = 1'b1;
      unique case (req.op)
        BFC_ROTATE_LEFT_CARRY: begin
          r = {req.operand[6:0], flagsIn[FLAG_C]};
          f = shiftFlags(flagsIn, r, req.operand[7]);
          nxt_state.writeBack = 1'b1;
        end
        BFC_ROTATE_RIGHT_CARRY: begin
          r = {flagsIn[FLAG_C], req.operand[7:1]};
          f = shiftFlags(flagsIn, r, req.operand[0]);
          nxt_state.writeBack = 1'b1;
        end
        BFC_LOGICAL_SHIFT_RIGHT: begin
          r = {1'b0, req.operand[7:1]};
          f = shiftFlags(flagsIn, r, req.operand[0]);
          nxt_state.writeBack = 1'b1;
        end
        BFC_ARITH_SHIFT_RIGHT: begin
          r = {req.operand[7], req.operand[7:1]};
          f = shiftFlags(flagsIn, r, req.operand[0]);
          nxt_state.writeBack = 1'b1;
        end
        BFC_NIBBLE_SWAP: begin
          r = {req.operand[3:0], req.operand[7:4]};
          nxt_state.writeBack = 1'b1;
        end
        BFC_BIT_TO_TRANSFER_FLAG: begin
          f[FLAG_T] = req.operand[req.bitSel];
        end
        BFC_TRANSFER_FLAG_TO_BIT: begin
          r[req.bitSel] = flagsIn[FLAG_T];
          nxt_state.writeBack = 1'b1;
        end
        BFC_SET_OVERFLOW_FLAG:   f[FLAG_V] = 1'b1;
        BFC_CLEAR_OVERFLOW_FLAG: f[FLAG_V] = 1'b0;
        BFC_SET_HALF_CARRY:      f[FLAG_H] = 1'b1;
        BFC_CLEAR_HALF_CARRY:    f[FLAG_H] = 1'b0;
        BFC_SET_SIGN_FLAG:       f[FLAG_S] = 1'b1;
        BFC_CLEAR_SIGN_FLAG:     f[FLAG_S] = 1'b0;
        BFC_SLEEP:               nxt_state.sleepReq = 1'b1;
        BFC_WATCHDOG_RESTART:    nxt_state.watchdogRestart = 1'b1;
        // Break completes at once here; the debug system decides any halt
        BFC_BREAK:               nxt_state.debugBreak = 1'b1;
        BFC_NOP:                 f = flagsIn;
        default:                 nxt_state.resultValid = 1'b0;
      endcase
      // Undefined codes retire nothing, so result and flags must hold
      if (nxt_state.resultValid) begin
        nxt_state.result = r;
        nxt_state.flags = f;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= '{resultValid: 1'b0, writeBack: 1'b0, result: DATA_RESET,
                    flags: FLAGS_RESET, sleepReq: 1'b0, watchdogRestart: 1'b0,
                    debugBreak: 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign resultValid     = state_ff.resultValid;
  assign writeBack       = state_ff.writeBack;
  assign result          = state_ff.result;
  assign flagsOut        = state_ff.flags;
  assign sleepReq        = state_ff.sleepReq;
  assign watchdogRestart = state_ff.watchdogRestart;
  assign debugBreak      = state_ff.debugBreak;

  ////////////////////////////////////////////////////////////////////////////////
  a_rol_result: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_ROTATE_LEFT_CARRY |=> result == {$past(req.operand[6:0]),
      $past(flagsIn[FLAG_C])} && flagsOut[FLAG_C] == $past(req.operand[7]) && resultValid)
    else $error("rotate left result or carry wrong");

  a_ror_result: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_ROTATE_RIGHT_CARRY |=> result == {$past(flagsIn[FLAG_C]),
      $past(req.operand[7:1])} && flagsOut[FLAG_C] == $past(req.operand[0]))
    else $error("rotate right result or carry wrong");

  a_bst_flag: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_BIT_TO_TRANSFER_FLAG |=> !writeBack &&
      flagsOut == {$past(flagsIn[7]), $past(req.operand[req.bitSel]), $past(flagsIn[5:0])})
    else $error("bit store changed the wrong flag");

  a_bld_bit: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_TRANSFER_FLAG_TO_BIT |=> writeBack &&
      result[$past(req.bitSel)] == $past(flagsIn[FLAG_T]) && flagsOut == $past(flagsIn))
    else $error("bit load result or flags wrong");

  a_ovf_set: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_SET_OVERFLOW_FLAG |=>
      flagsOut == ($past(flagsIn) | 8'h08))
    else $error("set overflow touched other flags");

  a_ovf_clear: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_CLEAR_OVERFLOW_FLAG |=>
      flagsOut == ($past(flagsIn) & 8'hF7))
    else $error("clear overflow touched other flags");

  a_half_set: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_SET_HALF_CARRY |=> flagsOut == ($past(flagsIn) | 8'h20))
    else $error("set half carry wrong");

  a_half_clear: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_CLEAR_HALF_CARRY |=> flagsOut == ($past(flagsIn) & 8'hDF))
    else $error("clear half carry wrong");

  a_sign_ops: assert property (@(posedge mclk) disable iff (rst)
    req.valid && (req.op == BFC_SET_SIGN_FLAG || req.op == BFC_CLEAR_SIGN_FLAG) |=>
      flagsOut[FLAG_S] == ($past(req.op) == BFC_SET_SIGN_FLAG) &&
      flagsOut[7:5] == $past(flagsIn[7:5]) && flagsOut[3:0] == $past(flagsIn[3:0]))
    else $error("sign flag operation wrong");

  a_sleep_pulse: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_SLEEP |=> sleepReq && flagsOut == $past(flagsIn)
      ##1 !sleepReq || $past(req.valid && req.op == BFC_SLEEP))
    else $error("sleep request wrong");

  a_wdog_pulse: assert property (@(posedge mclk) disable iff (rst)
    watchdogRestart |-> $past(req.valid && req.op == BFC_WATCHDOG_RESTART))
    else $error("watchdog restart without instruction");

  a_break_flags: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_BREAK |=> debugBreak && flagsOut == $past(flagsIn))
    else $error("break changed flags");

  a_shift_msb: assert property (@(posedge mclk) disable iff (rst)
    req.valid && (req.op == BFC_LOGICAL_SHIFT_RIGHT || req.op == BFC_ARITH_SHIFT_RIGHT) |=>
      result[7] == ($past(req.op) == BFC_ARITH_SHIFT_RIGHT && $past(req.operand[7])) &&
      flagsOut[FLAG_C] == $past(req.operand[0]) && flagsOut[FLAG_Z] == (result == 8'h00))
    else $error("right shift msb or flags wrong");

  a_swap_nibble: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_NIBBLE_SWAP |=> result == {$past(req.operand[3:0]),
      $past(req.operand[7:4])} && flagsOut == $past(flagsIn))
    else $error("nibble swap wrong");

  a_rol_flags: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_ROTATE_LEFT_CARRY |=> writeBack &&
      flagsOut[FLAG_Z] == ($past(req.operand[6:0]) == 7'h00 && !$past(flagsIn[FLAG_C])) &&
      flagsOut[FLAG_N] == $past(req.operand[6]) && flagsOut[7:5] == $past(flagsIn[7:5]))
    else $error("rotate left flags wrong");

  a_rol_overflow: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_ROTATE_LEFT_CARRY |=>
      flagsOut[FLAG_V] == ($past(req.operand[6]) ^ $past(req.operand[7])) &&
      flagsOut[FLAG_S] == $past(req.operand[7]))
    else $error("rotate left overflow or sign wrong");

  a_ror_flags: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_ROTATE_RIGHT_CARRY |=> writeBack && resultValid &&
      flagsOut[FLAG_N] == $past(flagsIn[FLAG_C]) &&
      flagsOut[FLAG_V] == ($past(flagsIn[FLAG_C]) ^ $past(req.operand[0])) &&
      flagsOut[FLAG_Z] == ($past(req.operand[7:1]) == 7'h00 && !$past(flagsIn[FLAG_C])) &&
      flagsOut[7:5] == $past(flagsIn[7:5]))
    else $error("rotate right flags wrong");

  a_lsr_flags: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_LOGICAL_SHIFT_RIGHT |=> writeBack && !flagsOut[FLAG_N] &&
      flagsOut[FLAG_V] == $past(req.operand[0]) &&
      flagsOut[FLAG_Z] == ($past(req.operand[7:1]) == 7'h00))
    else $error("logical shift right flags wrong");

  a_asr_flags: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_ARITH_SHIFT_RIGHT |=> writeBack &&
      flagsOut[FLAG_N] == $past(req.operand[7]) &&
      flagsOut[FLAG_V] == ($past(req.operand[7]) ^ $past(req.operand[0])) &&
      flagsOut[7:5] == $past(flagsIn[7:5]))
    else $error("arithmetic shift right flags wrong");

  a_shift_low: assert property (@(posedge mclk) disable iff (rst)
    req.valid && (req.op == BFC_LOGICAL_SHIFT_RIGHT || req.op == BFC_ARITH_SHIFT_RIGHT) |=>
      result[6:0] == $past(req.operand[7:1]))
    else $error("right shift low bits wrong");

  a_bld_others: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_TRANSFER_FLAG_TO_BIT |=> resultValid &&
      ((result ^ $past(req.operand)) & ~(8'h01 << $past(req.bitSel))) == 8'h00)
    else $error("bit load disturbed other bits");

  a_bst_retire: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_BIT_TO_TRANSFER_FLAG |=> resultValid &&
      !sleepReq && !watchdogRestart && !debugBreak)
    else $error("bit store did not retire alone");

  a_ovf_nowb: assert property (@(posedge mclk) disable iff (rst)
    req.valid && (req.op == BFC_SET_OVERFLOW_FLAG || req.op == BFC_CLEAR_OVERFLOW_FLAG) |=>
      resultValid && !writeBack)
    else $error("overflow operation wrote the register");

  a_ovf_clear_v: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_CLEAR_OVERFLOW_FLAG |=> !flagsOut[FLAG_V] && resultValid)
    else $error("clear overflow left overflow set");

  a_half_nowb: assert property (@(posedge mclk) disable iff (rst)
    req.valid && (req.op == BFC_SET_HALF_CARRY || req.op == BFC_CLEAR_HALF_CARRY) |=>
      resultValid && !writeBack && flagsOut[FLAG_H] == ($past(req.op) == BFC_SET_HALF_CARRY))
    else $error("half carry operation wrong");

  a_sign_nowb: assert property (@(posedge mclk) disable iff (rst)
    req.valid && (req.op == BFC_SET_SIGN_FLAG || req.op == BFC_CLEAR_SIGN_FLAG) |=>
      resultValid && !writeBack && flagsOut[FLAG_V] == $past(flagsIn[FLAG_V]))
    else $error("sign flag operation wrote the register");

  a_sleep_cause: assert property (@(posedge mclk) disable iff (rst)
    sleepReq |-> $past(req.valid && req.op == BFC_SLEEP) && resultValid && !writeBack)
    else $error("sleep request without instruction");

  a_wdog_flags: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_WATCHDOG_RESTART |=> watchdogRestart && !writeBack &&
      flagsOut == $past(flagsIn))
    else $error("watchdog restart missing or flags changed");

  a_break_cause: assert property (@(posedge mclk) disable iff (rst)
    debugBreak |-> $past(req.valid && req.op == BFC_BREAK) && !writeBack)
    else $error("debug break without instruction");

  a_pulse_onehot: assert property (@(posedge mclk) disable iff (rst)
    $onehot0({sleepReq, watchdogRestart, debugBreak}))
    else $error("more than one control pulse");

  // Every defined code retires exactly one cycle after it is taken
  a_retire_once: assert property (@(posedge mclk) disable iff (rst)
    resultValid == $past(req.valid && req.op <= BFC_BREAK))
    else $error("retire pulse not one cycle after request");

  a_wb_retired: assert property (@(posedge mclk) disable iff (rst)
    writeBack |-> resultValid)
    else $error("register write without a retired operation");

  a_swap_wb: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.op == BFC_NIBBLE_SWAP |=> writeBack && resultValid)
    else $error("nibble swap did not write back");

  // Idle cycles must not disturb what the register file may still read
  a_idle_hold: assert property (@(posedge mclk) disable iff (rst)
    !$past(rst) && !$past(req.valid) |->
      !resultValid && $stable(flagsOut) && $stable(result))
    else $error("outputs moved without a request");

endmodule // bfc_unit

// file: rtl/bfc_pkg.sv
// Package for the bit, flag and control operation unit
package bfc_pkg;

  localparam int DATA_W = 8;

  // Status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET  = 8'h00;

  // Clock rate and the single-cycle execution time of every operation
  localparam int MCLK_HZ      = 50000000;
  localparam int EXEC_TIME_NS = 20;
  localparam int EXEC_CYCLES  = (EXEC_TIME_NS * (MCLK_HZ / 1000000) + 999) / 1000;

  typedef enum logic [4:0] {
    BFC_NOP,
    BFC_ROTATE_LEFT_CARRY,
    BFC_ROTATE_RIGHT_CARRY,
    BFC_LOGICAL_SHIFT_RIGHT,
    BFC_ARITH_SHIFT_RIGHT,
    BFC_NIBBLE_SWAP,
    BFC_BIT_TO_TRANSFER_FLAG,
    BFC_TRANSFER_FLAG_TO_BIT,
    BFC_SET_OVERFLOW_FLAG,
    BFC_CLEAR_OVERFLOW_FLAG,
    BFC_SET_HALF_CARRY,
    BFC_CLEAR_HALF_CARRY,
    BFC_SET_SIGN_FLAG,
    BFC_CLEAR_SIGN_FLAG,
    BFC_SLEEP,
    BFC_WATCHDOG_RESTART,
    BFC_BREAK
  } bfc_op_t;

  typedef struct packed {
    logic       valid;
    bfc_op_t    op;
    logic [2:0] bitSel;
    logic [7:0] operand;
  } bfc_req_t;

  typedef struct packed {
    logic       resultValid;
    logic       writeBack;
    logic [7:0] result;
    logic [7:0] flags;
    logic       sleepReq;
    logic       watchdogRestart;
    logic       debugBreak;
  } bfc_state_t;

endpackage : bfc_pkg

// file: testbench/bfc_regfile_model.sv
// Register file and status flags standing behind the unit
`timescale 1ns/1ps
module bfc_regfile_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       resultValid,
  input  wire logic       writeBack,
  input  wire logic [7:0] result,
  input  wire logic [7:0] flagsOut,
  output logic [7:0]      regVal_ff,
  output logic [7:0]      flagVal_ff
);
  always_ff @(posedge mclk) begin
    if (rst) begin
      regVal_ff  <= 8'h00;
      flagVal_ff <= 8'h00;
    end else begin
      // Flags land on every retired op, the register only on write-back
      if (resultValid) flagVal_ff <= flagsOut;
      if (writeBack) regVal_ff <= result;
    end
  end
endmodule // bfc_regfile_model

// file: testbench/bfc_unit_tb.sv
// Self-checking bench for the bit, flag and control unit
`timescale 1ns/1ps
module bfc_unit_tb;
  import bfc_pkg::*;
  typedef struct packed {
    logic       wb;
    logic [7:0] res;
    logic [7:0] fl;
    logic [2:0] ctl;
  } bfc_exp_t;
  logic       mclk, rst, resultValid, writeBack, sleepReq, watchdogRestart, debugBreak;
  logic [7:0] flagsIn, result, flagsOut, regVal, flagVal, lastRes;
  bfc_req_t   req;
  bfc_exp_t   cur, prev;
  int         badCount = 0;
  int         numChecks = 0;
  bit         have = 0;
  logic [7:0] opnd [3] = '{8'h81, 8'h01, 8'hC6};
  logic [7:0] flg [3]  = '{8'h00, 8'hFF, 8'h5A};

  bfc_unit dut (.mclk(mclk), .rst(rst), .req(req), .flagsIn(flagsIn),
    .resultValid(resultValid), .writeBack(writeBack), .result(result), .flagsOut(flagsOut),
    .sleepReq(sleepReq), .watchdogRestart(watchdogRestart), .debugBreak(debugBreak));
  bfc_regfile_model rf (.mclk(mclk), .rst(rst), .resultValid(resultValid),
    .writeBack(writeBack), .result(result), .flagsOut(flagsOut),
    .regVal_ff(regVal), .flagVal_ff(flagVal));

  ////////////////////////////////////////////////////////////////////////////
  function automatic bfc_exp_t predict(bfc_op_t op, logic [2:0] b, logic [7:0] a, logic [7:0] f);
    bfc_exp_t e;
    logic     c;
    e = '0;
    e.res = a;
    e.fl = f;
    c = f[FLAG_C];
    case (op)
      BFC_ROTATE_LEFT_CARRY:    {c, e.res} = {a, f[FLAG_C]};
      BFC_ROTATE_RIGHT_CARRY:   {e.res, c} = {f[FLAG_C], a};
      BFC_LOGICAL_SHIFT_RIGHT:  {e.res, c} = {1'b0, a};
      BFC_ARITH_SHIFT_RIGHT:    {e.res, c} = {a[7], a};
      BFC_NIBBLE_SWAP:          e.res = {a[3:0], a[7:4]};
      BFC_BIT_TO_TRANSFER_FLAG: e.fl[FLAG_T] = a[b];
      BFC_TRANSFER_FLAG_TO_BIT: e.res[b] = f[FLAG_T];
      BFC_SET_OVERFLOW_FLAG:    e.fl[FLAG_V] = 1'b1;
      BFC_CLEAR_OVERFLOW_FLAG:  e.fl[FLAG_V] = 1'b0;
      BFC_SET_HALF_CARRY:       e.fl[FLAG_H] = 1'b1;
      BFC_CLEAR_HALF_CARRY:     e.fl[FLAG_H] = 1'b0;
      BFC_SET_SIGN_FLAG:        e.fl[FLAG_S] = 1'b1;
      BFC_CLEAR_SIGN_FLAG:      e.fl[FLAG_S] = 1'b0;
      BFC_SLEEP:                e.ctl = 3'h4;
      BFC_WATCHDOG_RESTART:     e.ctl = 3'h2;
      BFC_BREAK:                e.ctl = 3'h1;
      default:                  e.ctl = 3'h0;
    endcase
    e.wb = op inside {[BFC_ROTATE_LEFT_CARRY:BFC_NIBBLE_SWAP], BFC_TRANSFER_FLAG_TO_BIT};
    if (op inside {[BFC_ROTATE_LEFT_CARRY:BFC_ARITH_SHIFT_RIGHT]}) begin
      e.fl[FLAG_C] = c;
      e.fl[FLAG_Z] = (e.res == 8'h00);
      e.fl[FLAG_N] = e.res[7];
      e.fl[FLAG_V] = e.res[7] ^ c;
      e.fl[FLAG_S] = c;
    end
    return e;
  endfunction

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    numChecks++;
    if (g !== e) begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_out(input bfc_exp_t e, input logic v);
    chk("resultValid", {7'h00, v}, {7'h00, resultValid});
    chk("writeBack", {7'h00, e.wb & v}, {7'h00, writeBack});
    if (e.wb) chk("result", e.res, result);
    chk("flagsOut", e.fl, flagsOut);
    chk("pulses", {5'h00, e.ctl & {3{v}}}, {5'h00, sleepReq, watchdogRestart, debugBreak});
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    #(400 * 20);
    badCount++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    req = '0;
    flagsIn = 8'h00;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("resetOut", 8'h00, {writeBack, resultValid, sleepReq, watchdogRestart, debugBreak, 3'h0});
    chk("resetFlags", 8'h00, flagsOut);
    chk("resetResult", 8'h00, result);
    // Back to back, every op, three operand and flag sets
    for (int p = 0; p < 3; p++) begin
      for (int o = 0; o <= 16; o++) begin
        @(posedge mclk);
        req <= '{valid: 1'b1, op: bfc_op_t'(o), bitSel: 3'(o + p), operand: opnd[p]};
        flagsIn <= flg[p];
        cur = predict(bfc_op_t'(o), 3'(o + p), opnd[p], flg[p]);
        #1;
        if (have) check_out(prev, 1'b1);
        if (have && prev.wb) lastRes = prev.res;
        prev = cur;
        have = 1;
      end
    end
    @(posedge mclk);
    req.valid <= 1'b0;
    #1;
    check_out(prev, 1'b1);
    @(posedge mclk);
    #1;
    check_out(prev, 1'b0);
    chk("modelReg", lastRes, regVal);
    chk("modelFlags", prev.fl, flagVal);
    // Undefined code: nothing retires and the flags hold
    @(posedge mclk);
    req <= '{valid: 1'b1, op: bfc_op_t'(5'h11), bitSel: 3'h0, operand: 8'h3C};
    flagsIn <= 8'hA5;
    @(posedge mclk);
    req.valid <= 1'b0;
    #1;
    check_out(prev, 1'b0);
    report_and_stop();
  end
endmodule // bfc_unit_tb
